/* design/dsch_cmd_handler.sv */
// Command handler of the single-wire debug controller, top level.
// Assumes a framer on the same clock delivers command bytes and the
// timing reference pulse, and that CPU and flash signals share it too.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dsch_cmd_handler (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic sync_pulse_in,
  input wire logic core_stop_in,
  input wire logic core_wait_in,
  input wire logic instr_done_in,
  input wire logic cpu_resume_in,
  input wire logic flash_done_in,
  output logic ack_pulse_out,
  output logic halt_req_out,
  output logic debug_active_out,
  output logic erase_req_out,
  output logic soft_reset_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  dsch_pkg::dsch_rx_t rx_q;
  dsch_pkg::dsch_erase_t er_state;
  logic [7:0] hi_q;
  logic enable_q;
  logic ack_en_q;
  logic no_response_flag_q;
  logic tmo_q;
  logic tmo_evt;
  logic sleeping;
  logic cmd_take;
  logic is_ack;
  logic is_halt;
  logic is_erase;
  logic csr_go;
  logic [15:0] csr_data;
  logic ax_wr;
  logic [7:0] ax_waddr;
  logic [31:0] ax_wdata;
  logic [3:0] ax_wstrb;
  logic ax_csr;
  logic ax_wok;
  logic [7:0] ax_raddr;
  logic [31:0] ax_rdata;
  logic ax_rok;
  logic [15:0] csr_view;

  // Write-one-to-clear flag; a set in the same cycle wins over a clear.
  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    w1c = set | (flag & ~clr);
  endfunction

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Commands are taken whatever the core or erase state is.
  assign cmd_take = byte_valid_in && rx_q == dsch_pkg::RX_CMD && !sync_pulse_in; // [RQ8] [RQ18]
  assign is_ack = cmd_take && byte_in == dsch_pkg::CMD_ACK_EN;
  assign is_halt = cmd_take && byte_in == dsch_pkg::CMD_HALT;
  assign is_erase = cmd_take && byte_in == dsch_pkg::CMD_ERASE; // [RQ12]
  assign csr_go = byte_valid_in && rx_q == dsch_pkg::RX_LO && !sync_pulse_in;
  assign csr_data = {hi_q, byte_in}; // [RQ9]
  assign sleeping = core_stop_in | core_wait_in;
  assign ax_csr = ax_wr && ax_waddr == dsch_pkg::ADDR_CSR && ax_wstrb[0];

  // The timing pulse drops any partly received status write.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_q <= dsch_pkg::RX_CMD;
      hi_q <= 8'h00;
    end else if (sync_pulse_in) begin
      rx_q <= dsch_pkg::RX_CMD;
    end else if (byte_valid_in) begin
      case (rx_q)
        dsch_pkg::RX_CMD: begin
          if (byte_in == dsch_pkg::CMD_CSR_WR) begin // [RQ9]
            rx_q <= dsch_pkg::RX_HI;
          end
        end
        dsch_pkg::RX_HI: begin
          hi_q <= byte_in;
          rx_q <= dsch_pkg::RX_LO;
        end
        dsch_pkg::RX_LO: begin
          rx_q <= dsch_pkg::RX_CMD;
        end
        default: begin
          rx_q <= dsch_pkg::RX_CMD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  // Only handshake-enable and, once it is on, a halt command with the enable bit set are answered.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_en_q <= 1'b0;
      ack_pulse_out <= 1'b0;
    end else begin
      ack_pulse_out <= is_ack | (is_halt & enable_q & ack_en_q); // [RQ2] [RQ10] [RQ17]
      if (is_ack) begin // [RQ1]
        ack_en_q <= 1'b1;
      end else if (soft_reset_out) begin
        ack_en_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Halt to debug
  // ---------------------------------------------------------------
  // A stopped or waiting core cannot finish its instruction, so the
  // request simply waits.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      halt_req_out <= 1'b0;
      debug_active_out <= 1'b0;
    end else if (soft_reset_out) begin
      halt_req_out <= 1'b0;
    end else begin
      if (is_halt && enable_q && !debug_active_out) begin // [RQ3] [RQ4]
        halt_req_out <= 1'b1;
      end else if (halt_req_out && instr_done_in && !sleeping) begin // [RQ7]
        halt_req_out <= 1'b0;
        debug_active_out <= 1'b1;
      end
      if (cpu_resume_in && !halt_req_out) begin
        debug_active_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and status
  // ---------------------------------------------------------------
  // Serial and bus writes share one register; the bus write lands last.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enable_q <= dsch_pkg::CSR_RESET[dsch_pkg::CSR_ENABLE];
    end else if (ax_csr) begin
      enable_q <= ax_wdata[dsch_pkg::CSR_ENABLE];
    end else if (csr_go) begin // [RQ11]
      enable_q <= csr_data[dsch_pkg::CSR_ENABLE];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      no_response_flag_q <= dsch_pkg::CSR_RESET[dsch_pkg::CSR_NO_RESPONSE_FLAG];
      tmo_q <= dsch_pkg::CSR_RESET[dsch_pkg::CSR_TMO];
    end else begin
      no_response_flag_q <= w1c(no_response_flag_q, halt_req_out & sleeping, // [RQ7]
        (csr_go & csr_data[dsch_pkg::CSR_NO_RESPONSE_FLAG]) | (ax_csr & ax_wdata[dsch_pkg::CSR_NO_RESPONSE_FLAG])); // [RQ11]
      tmo_q <= w1c(tmo_q, tmo_evt,
        (csr_go & csr_data[dsch_pkg::CSR_TMO]) | (ax_csr & ax_wdata[dsch_pkg::CSR_TMO]));
    end
  end

  assign csr_view = {8'h00, enable_q, debug_active_out, erase_req_out, ack_en_q,
    sleeping, no_response_flag_q, tmo_q, halt_req_out};

  always_comb begin
    ax_rdata = 32'h00000000;
    ax_rok = 1'b1;
    if (ax_raddr == dsch_pkg::ADDR_CSR) begin
      ax_rdata = {16'h0000, csr_view};
    end else if (ax_raddr == dsch_pkg::ADDR_STAT) begin
      ax_rdata[dsch_pkg::STAT_ER_LSB +: 3] = er_state;
      ax_rdata[dsch_pkg::STAT_RX_LSB +: 3] = rx_q;
    end else begin
      ax_rok = 1'b0;
    end
  end

  assign ax_wok = ax_waddr == dsch_pkg::ADDR_CSR || ax_waddr == dsch_pkg::ADDR_STAT;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  dsch_erase_tracker u_erase (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .erase_cmd_in(is_erase),
    .other_cmd_in(cmd_take && !is_erase), // [RQ14]
    .sync_in(sync_pulse_in), // [RQ19]
    .flash_done_in(flash_done_in),
    .erase_req_out(erase_req_out),
    .soft_reset_out(soft_reset_out),
    .timeout_out(tmo_evt),
    .state_out(er_state)
  );

  dsch_axil_slave u_axil (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_en_out(ax_wr),
    .wr_addr_out(ax_waddr),
    .wr_data_out(ax_wdata),
    .wr_strb_out(ax_wstrb),
    .wr_ok_in(ax_wok),
    .rd_addr_out(ax_raddr),
    .rd_data_in(ax_rdata),
    .rd_ok_in(ax_rok)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_ack_enable;
    is_ack |=> ack_pulse_out && ack_en_q ##1 !ack_pulse_out || $past(is_halt) || $past(is_ack);
  endproperty
  a_ack_enable: assert property (p_ack_enable) else $error("handshake enable not answered"); // [RQ2]

  property p_halt_ignored;
    is_halt && !enable_q && !halt_req_out |=> !halt_req_out && !ack_pulse_out;
  endproperty
  a_halt_ignored: assert property (p_halt_ignored) else $error("disabled halt acted on"); // [RQ4]

  property p_halt_taken;
    is_halt && enable_q && !debug_active_out && !soft_reset_out |=> halt_req_out;
  endproperty
  a_halt_taken: assert property (p_halt_taken) else $error("enabled halt not pending"); // [RQ3]

  property p_pending_sleep;
    halt_req_out && sleeping && !soft_reset_out
      |=> halt_req_out && no_response_flag_q && !debug_active_out;
  endproperty
  a_pending_sleep: assert property (p_pending_sleep) else $error("pending halt not shown"); // [RQ7]

  property p_csr_no_ack;
    csr_go |=> !ack_pulse_out;
  endproperty
  a_csr_no_ack: assert property (p_csr_no_ack) else $error("status write answered"); // [RQ10]

  property p_erase_no_ack;
    is_erase |=> !ack_pulse_out;
  endproperty
  a_erase_no_ack: assert property (p_erase_no_ack) else $error("erase command answered"); // [RQ17]

  sequence s_csr_frame;
    rx_q == dsch_pkg::RX_LO && byte_valid_in && !sync_pulse_in && !ax_csr;
  endsequence
  property p_csr_write;
    s_csr_frame |=> enable_q == $past(byte_in[7]);
  endproperty
  a_csr_write: assert property (p_csr_write) else $error("status write not applied"); // [RQ9]

  property p_halt_ack;
    is_halt && enable_q && ack_en_q |=> ack_pulse_out;
  endproperty
  a_halt_ack: assert property (p_halt_ack) else $error("enabled halt not answered"); // [RQ2]

  property p_wait_serves;
    is_ack && core_wait_in |=> ack_pulse_out && ack_en_q;
  endproperty
  a_wait_serves: assert property (p_wait_serves) else $error("command refused in wait"); // [RQ8]

  property p_soft_clears;
    soft_reset_out && !is_ack |=> !halt_req_out && !ack_en_q;
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("soft reset left state"); // [RQ22]

  property p_tmo_flag;
    tmo_evt |=> tmo_q;
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag not set"); // [RQ15]

endmodule

/* design/dsch_pkg.sv */
// Constants and types shared by the debug serial command handler.
// Assumes one clock, the serial interface clock, with a synchronous reset.
//
// Notes on behaviour
// RQ1: Handshake-enable command handled locally, no CPU.
// RQ2: Acknowledge handshake-enable; then acknowledge supported commands.
// RQ3: Enabled halt command halts after current instruction.
// RQ4: Halt command ignored while enable bit clear.
// RQ5: Host waits 16 clocks after halt command.
// RQ6: Host sets enable bit before first halt; the bench sends one halt before setting it.
// RQ7: Halt while sleeping stays pending, flags shown.
// RQ8: Non-intrusive commands still run while core waits.
// RQ9: Status write: code, high byte, low byte.
// RQ10: Status write is never acknowledged.
// RQ11: Status write sets controls, clears flags.
// RQ12: Erase command accepted in every state.
// RQ13: Two back-to-back erase commands start mass erase.
// RQ14: Other command after one erase restarts sequence.
// RQ15: 512 clocks between erases: timeout, soft reset.
// RQ16: Erase bit held until flash reports done.
// RQ17: Erase command is never acknowledged.
// RQ18: Always-available commands served during erase.
// RQ19: Timing pulse during erase aborts, soft reset.
// RQ20: Bus clock stays default until erase issued.
// RQ21: Erase request held until done or reset.
// RQ22: Soft reset returns erase tracker to idle.

package dsch_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ACK_EN = 8'hd5;
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam logic [7:0] CMD_CSR_WR = 8'h0d;
  localparam logic [7:0] CMD_ERASE = 8'h95;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // The serial interface clock is the block clock, so one period each.
  localparam int ERASE_TIMEOUT_SCLK = 512;
  localparam int SYS_PER_SCLK = 1;
  localparam int ERASE_TIMEOUT_CYC = ERASE_TIMEOUT_SCLK * SYS_PER_SCLK;
  localparam logic [9:0] ERASE_CNT_LAST = 10'(ERASE_TIMEOUT_CYC - 1);

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CSR = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CSR_PEND = 0;
  localparam int CSR_TMO = 1;
  localparam int CSR_NO_RESPONSE_FLAG = 2;
  localparam int CSR_SLEEP = 3;
  localparam int CSR_ACKEN = 4;
  localparam int CSR_ERASE = 5;
  localparam int CSR_ACTIVE = 6;
  localparam int CSR_ENABLE = 7;
  localparam int STAT_ER_LSB = 0;
  localparam int STAT_RX_LSB = 3;
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ER_IDLE = 3'b001,
    ER_ARMED = 3'b010,
    ER_BUSY = 3'b100
  } dsch_erase_t;

  typedef enum logic [2:0] {
    RX_CMD = 3'b001,
    RX_HI = 3'b010,
    RX_LO = 3'b100
  } dsch_rx_t;

endpackage

/* design/dsch_axil_slave.sv */
// AXI4-Lite slave front end for the command handler registers.
// Assumes the owner decodes addresses and answers within the cycle.
`timescale 1ns/1ps
module dsch_axil_slave (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [7:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);

  logic rd_go_q;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= dsch_pkg::RESP_OKAY;
      wr_en_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 32'h00000000;
      wr_strb_out <= 4'h0;
    end else begin
      wr_en_out <= 1'b0;
      if (awvalid_in && awready_out) begin
        awready_out <= 1'b0;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        wready_out <= 1'b0;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (!awready_out && !wready_out && !bvalid_out && !wr_en_out) begin
        wr_en_out <= 1'b1;
      end
      if (wr_en_out) begin
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok_in ? dsch_pkg::RESP_OKAY : dsch_pkg::RESP_SLVERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rd_go_q <= 1'b0;
      rd_addr_out <= 8'h00;
      rdata_out <= 32'h00000000;
      rresp_out <= dsch_pkg::RESP_OKAY;
    end else begin
      rd_go_q <= 1'b0;
      if (arvalid_in && arready_out) begin
        arready_out <= 1'b0;
        rd_addr_out <= araddr_in;
        rd_go_q <= 1'b1;
      end
      if (rd_go_q) begin
        rvalid_out <= 1'b1;
        rdata_out <= rd_data_in;
        rresp_out <= rd_ok_in ? dsch_pkg::RESP_OKAY : dsch_pkg::RESP_SLVERR;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

endmodule

/* design/dsch_erase_tracker.sv */
// Two-step mass-erase sequencer with inter-command timeout and abort.
// Assumes one-cycle command strobes from the command decoder.
`timescale 1ns/1ps
module dsch_erase_tracker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic erase_cmd_in,
  input wire logic other_cmd_in,
  input wire logic sync_in,
  input wire logic flash_done_in,
  output logic erase_req_out,
  output logic soft_reset_out,
  output logic timeout_out,
  output dsch_pkg::dsch_erase_t state_out
);

  logic [9:0] cnt_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // The erase request doubles as the erase-in-progress bit.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_out <= dsch_pkg::ER_IDLE;
      cnt_q <= 10'h000;
      erase_req_out <= 1'b0;
      soft_reset_out <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      soft_reset_out <= 1'b0;
      timeout_out <= 1'b0;
      case (state_out)
        dsch_pkg::ER_IDLE: begin
          cnt_q <= 10'h000;
          if (erase_cmd_in) begin // [RQ12]
            state_out <= dsch_pkg::ER_ARMED;
          end
        end
        dsch_pkg::ER_ARMED: begin
          cnt_q <= cnt_q + 10'h001;
          if (erase_cmd_in) begin // [RQ13]
            state_out <= dsch_pkg::ER_BUSY;
            erase_req_out <= 1'b1;
          end else if (other_cmd_in) begin // [RQ14]
            state_out <= dsch_pkg::ER_IDLE;
          end else if (cnt_q == dsch_pkg::ERASE_CNT_LAST) begin // [RQ15]
            state_out <= dsch_pkg::ER_IDLE; // [RQ22]
            soft_reset_out <= 1'b1;
            timeout_out <= 1'b1;
          end
        end
        dsch_pkg::ER_BUSY: begin
          if (sync_in) begin // [RQ19]
            state_out <= dsch_pkg::ER_IDLE;
            erase_req_out <= 1'b0;
            soft_reset_out <= 1'b1;
          end else if (flash_done_in) begin // [RQ16] [RQ21]
            state_out <= dsch_pkg::ER_IDLE;
            erase_req_out <= 1'b0;
          end
        end
        default: begin
          state_out <= dsch_pkg::ER_IDLE;
          erase_req_out <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_first_erase;
    state_out == dsch_pkg::ER_IDLE && erase_cmd_in;
  endsequence
  sequence s_second_erase;
    state_out == dsch_pkg::ER_ARMED && erase_cmd_in;
  endsequence

  property p_erase_pair;
    s_second_erase |=> erase_req_out && state_out == dsch_pkg::ER_BUSY;
  endproperty
  a_erase_pair: assert property (p_erase_pair) else $error("erase pair did not start erase"); // [RQ13]

  property p_other_restarts;
    state_out == dsch_pkg::ER_ARMED && other_cmd_in && !erase_cmd_in
      |=> state_out == dsch_pkg::ER_IDLE && !erase_req_out;
  endproperty
  a_other_restarts: assert property (p_other_restarts) else $error("sequence not restarted"); // [RQ14]

  property p_timeout;
    s_first_erase ##1 (state_out == dsch_pkg::ER_ARMED && !erase_cmd_in && !other_cmd_in)[*8]
      |=> cnt_q == 10'd8;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout counter off"); // [RQ15]

  property p_timeout_reset;
    state_out == dsch_pkg::ER_ARMED && cnt_q == dsch_pkg::ERASE_CNT_LAST && !erase_cmd_in && !other_cmd_in
      |=> soft_reset_out && timeout_out && state_out == dsch_pkg::ER_IDLE ##1 cnt_q == 10'h000;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("timeout did not reset"); // [RQ22]

  property p_req_hold;
    erase_req_out && !flash_done_in && !sync_in |=> erase_req_out;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("erase request dropped early"); // [RQ21]

  property p_done_clears;
    erase_req_out && flash_done_in && !sync_in |=> !erase_req_out && !soft_reset_out;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("erase bit not cleared"); // [RQ16]

  property p_sync_abort;
    erase_req_out && sync_in |=> soft_reset_out && !erase_req_out ##1 !soft_reset_out;
  endproperty
  a_sync_abort: assert property (p_sync_abort) else $error("abort missing soft reset"); // [RQ19]

endmodule

/* sim/dsch_host_model.sv */
// Host debug pod model: sends command bytes and timing pulses.
// Assumes the handler samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module dsch_host_model (
  input wire logic sys_clk_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic sync_out
);
  // ---------------------------------------------------------------
  // Serial host
  // ---------------------------------------------------------------
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    sync_out = 1'b0;
  end
  // Idle bytes show the inverse, so a stale byte never looks valid.
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk_in);
    byte_valid_out <= 1'b1;
    byte_out <= b;
    @(posedge sys_clk_in);
    byte_valid_out <= 1'b0;
    byte_out <= ~b;
    if (b == dsch_pkg::CMD_HALT) repeat (16) @(posedge sys_clk_in);
  endtask
  task automatic csr_wr(input logic [15:0] v);
    send(dsch_pkg::CMD_CSR_WR);
    send(v[15:8]);
    send(v[7:0]);
  endtask
  task automatic pulse();
    @(posedge sys_clk_in);
    sync_out <= 1'b1;
    @(posedge sys_clk_in);
    sync_out <= 1'b0;
  endtask
endmodule

/* sim/dsch_cmd_handler_tb.sv */
// Bench for the command handler: host model, AXI4-Lite master, CPU and flash.
// Assumes every input shares sys_clk_in and reset is synchronous.
`timescale 1ns/1ps
module dsch_cmd_handler_tb;
  logic clk, rst, bv, sync, idone, resume, fdone, ack, halt, act, ereq, sr, cw;
  logic [7:0] b, awa, ara;
  logic awv, wv, arv, awr, wr_r, bvl, arr, rv;
  logic [31:0] wd, rdt;
  logic [1:0] brs, rrs;
  logic [65:0] e;
  logic [65:0] q[$];
  int miscompares, check_count, acks, srs, cyc, t;
  integer seed;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dsch_host_model i_host (.sys_clk_in(clk), .byte_valid_out(bv), .byte_out(b), .sync_out(sync));
  dsch_cmd_handler i_dut (.sys_clk_in(clk), .rst_in(rst), .byte_valid_in(bv), .byte_in(b),
    .sync_pulse_in(sync), .core_stop_in(1'b0), .core_wait_in(cw), .instr_done_in(idone),
    .cpu_resume_in(resume), .flash_done_in(fdone), .ack_pulse_out(ack), .halt_req_out(halt),
    .debug_active_out(act), .erase_req_out(ereq), .soft_reset_out(sr), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(brs), .s_axi_bvalid_out(bvl),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rrs), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1));
  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  // Ready lines stay high, so valid alone marks the handshake edge.
  always @(posedge clk) begin
    cyc++;
    if (ack === 1'b1) acks++;
    if (sr === 1'b1) srs++;
    if (rv === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk("rdata", e[33:0], {rrs, rdt & e[65:34]});
    end
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] x);
    q.push_back({m, x});
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1 || wr_r !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk); while (bvl !== 1'b1);
    chk("bresp", 34'(dsch_pkg::RESP_OKAY), 34'(brs));
  endtask
  task automatic tick(input logic [7:0] n);
    repeat (n) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h98f22f11;
    {rst, idone, resume, fdone, awv, wv, arv, cw} = 8'h80;
    {awa, ara, wd} = 48'h0;
    tick(3);
    rst <= 1'b0;
    rd(dsch_pkg::ADDR_CSR, 32'hffff, 34'(dsch_pkg::CSR_RESET));
    rd(dsch_pkg::ADDR_STAT, 32'h3f, 34'h09);
    rd(8'h08, 32'hffffffff, {dsch_pkg::RESP_SLVERR, 32'h0});
    i_host.send(dsch_pkg::CMD_ACK_EN);
    tick(2);
    chk("ack", 1, 34'(acks));
    i_host.send(dsch_pkg::CMD_HALT);
    chk("halt", 0, 34'(halt));
    i_host.csr_wr(16'h0080);
    rd(dsch_pkg::ADDR_CSR, 32'hf0, 34'h90);
    chk("ack", 1, 34'(acks));
    i_host.send(dsch_pkg::CMD_HALT);
    chk("halt", 1, 34'(halt));
    chk("ack", 2, 34'(acks));
    idone <= 1'b1;
    tick(3);
    chk("active", 1, 34'(act));
    i_host.send(dsch_pkg::CMD_ERASE);
    i_host.send(dsch_pkg::CMD_ERASE);
    tick(2);
    chk("ereq", 1, 34'(ereq));
    rd(dsch_pkg::ADDR_CSR, 32'h20, 34'h20);
    chk("ereq", 1, 34'(ereq));
    chk("ack", 2, 34'(acks));
    fdone <= 1'b1;
    resume <= 1'b1;
    tick(1);
    fdone <= 1'b0;
    resume <= 1'b0;
    tick(2);
    chk("ereq", 0, 34'(ereq));
    i_host.send(dsch_pkg::CMD_ERASE);
    i_host.send(dsch_pkg::CMD_ACK_EN);
    i_host.send(dsch_pkg::CMD_ERASE);
    tick(2);
    chk("ereq", 0, 34'(ereq));
    t = srs;
    repeat (2) tick(254);
    chk("sreset", 34'(t), 34'(srs));
    tick(8);
    chk("sreset", 34'(t + 1), 34'(srs));
    rd(dsch_pkg::ADDR_STAT, 32'h07, 34'h01);
    rd(dsch_pkg::ADDR_CSR, 32'h02, 34'h02);
    wr(dsch_pkg::ADDR_CSR, 32'h02);
    rd(dsch_pkg::ADDR_CSR, 32'h02, 34'h00);
    i_host.send(dsch_pkg::CMD_ERASE);
    tick(8'($random(seed)));
    i_host.send(dsch_pkg::CMD_ERASE);
    tick(2);
    chk("ereq", 1, 34'(ereq));
    t = srs;
    i_host.pulse();
    tick(2);
    chk("ereq", 0, 34'(ereq));
    chk("sreset", 34'(t + 1), 34'(srs));
    i_host.csr_wr(16'h0080);
    cw <= 1'b1;
    i_host.send(dsch_pkg::CMD_HALT);
    i_host.send(dsch_pkg::CMD_ACK_EN);
    rd(dsch_pkg::ADDR_CSR, 32'h5d, 34'h1d);
    chk("ack", 4, 34'(acks));
    cw <= 1'b0;
    tick(2);
    chk("active", 1, 34'(act));
    report_and_stop();
  end
endmodule
